// >>> core/flw_watchdog.sv
// firmware lockup watchdog: write-once period, keyed arm and kick, reset pulse
// Notes on behaviour
// (R1) load period, then 0Fh, F0h arms
// (R2) arm/kick register always reads zero
// (R3) once armed, only reset stops it
// (R4) inactive after reset until full sequence
// (R5) timeout equals N millisecond ticks, N 0-255
// (R6) period register reads back accepted N
// (R7) only first period write takes effect
// (R8) stray bytes after 0Fh ignored, F0h arms
// (R9) kick only by alternating 0Fh, F0h
// (R10) timeout may run up to one tick long
// (R11) firmware starts the millisecond tick first
// (R12) counter advances only on millisecond tick
// (R13) arm and kick reload counter from period
// (R14) one decrement per tick, on clock edge
// (R15) at zero, next tick fires both resets
// (R16) resets release eight clocks after firing
// (R17) period zero fires at first tick
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "flw_consts.svh"
module flw_watchdog #(
  parameter int unsigned PERIOD_W = 8,
  parameter int unsigned HOLD_W   = 4
) (
  // clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_b_i,
  // register port
  input  wire logic [`FLW_ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]             reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [7:0]             reg_rdata_o,
  // timing chain
  input  wire logic                   millisecond_tick_i,
  // reset outputs and status
  output logic                        wdog_int_rst_o,
  output logic                        board_rst_out_n_o,
  output logic                        wdog_armed_o
);

  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(`FLW_RST_HOLD_CLKS - 1);

  // address compare used by both read and write decode
  function automatic logic hit(input logic [`FLW_ADDR_W-1:0] a,
                               input logic [`FLW_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic [PERIOD_W-1:0] period_ff;
  logic                period_lock_ff;
  flw_pkg::flw_arm_t   seq_ff;
  logic                armed_ff;
  logic [PERIOD_W-1:0] count_ff;
  logic                firing_ff;
  logic [HOLD_W-1:0]   hold_ff;

  // write and read decode
  wire wr_kick   = reg_wr_i & hit(reg_addr_i, `FLW_OFF_ARM_KICK_LOW);
  wire wr_period = reg_wr_i & hit(reg_addr_i, `FLW_OFF_PERIOD_LOW);
  wire rd_period = reg_rd_i & hit(reg_addr_i, `FLW_OFF_PERIOD_LOW);
  wire key_first  = wr_kick & (reg_wdata_i == `FLW_KEY_FIRST);
  wire key_second = wr_kick & (reg_wdata_i == `FLW_KEY_SECOND);
  // second key completes an arm or a kick; other bytes leave the state alone
  wire key_done = key_second & (seq_ff == flw_pkg::FLW_SEEK_SECOND); // see (R8) see (R9)
  wire expired  = armed_ff & ~firing_ff & (count_ff == '0) & millisecond_tick_i; // see (R15) see (R17)

  // sequencer: waits for period load, then alternates 0Fh / F0h
  flw_pkg::flw_arm_t nxt_seq;
  always_comb begin
    nxt_seq = seq_ff;
    case (seq_ff)
      flw_pkg::FLW_IDLE:        if (period_lock_ff) nxt_seq = flw_pkg::FLW_SEEK_FIRST; // see (R1)
      flw_pkg::FLW_SEEK_FIRST:  if (key_first) nxt_seq = flw_pkg::FLW_SEEK_SECOND;
      flw_pkg::FLW_SEEK_SECOND: if (key_done) nxt_seq = flw_pkg::FLW_SEEK_FIRST;
      default:                  nxt_seq = flw_pkg::FLW_IDLE;
    endcase
  end

  // period register, write-once after reset
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      period_ff      <= PERIOD_W'(`FLW_RST_PERIOD);
      period_lock_ff <= 1'b0;
    end else if (wr_period && !period_lock_ff) begin // see (R7)
      period_ff      <= reg_wdata_i[PERIOD_W-1:0]; // see (R5)
      period_lock_ff <= 1'b1;
    end
  end

  // arm state and key sequencer
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seq_ff   <= flw_pkg::FLW_IDLE; // see (R4)
      armed_ff <= 1'b0;
    end else begin
      seq_ff <= nxt_seq;
      if (key_done) armed_ff <= 1'b1; // never cleared by a write, see (R3)
    end
  end

  // down counter: reload on arm/kick, step only on the shared tick; the tick is
  // free-running so the first step may fall anywhere in the first millisecond,
  // which lets the timeout run up to one tick long, see (R10)
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_ff <= '0;
    end else if (key_done) begin
      count_ff <= period_ff; // see (R13)
    end else if (armed_ff && millisecond_tick_i && count_ff != '0) begin
      count_ff <= count_ff - PERIOD_W'(1); // see (R12) see (R14)
    end
  end

  // reset pulse generator, held for a fixed number of clocks then released
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      firing_ff <= 1'b0;
      hold_ff   <= '0;
    end else if (expired) begin
      firing_ff <= 1'b1;
      hold_ff   <= '0;
    end else if (firing_ff) begin
      hold_ff <= hold_ff + HOLD_W'(1);
      if (hold_ff == HOLD_LAST) firing_ff <= 1'b0; // see (R16)
    end
  end

  // outputs; firing also drives the system reset that clears this block
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wdog_int_rst_o    <= 1'b0;
      board_rst_out_n_o <= 1'b1;
      wdog_armed_o      <= 1'b0;
    end else begin
      wdog_int_rst_o    <= expired | (firing_ff & hold_ff != HOLD_LAST); // see (R15)
      board_rst_out_n_o <= ~(expired | (firing_ff & hold_ff != HOLD_LAST));
      wdog_armed_o      <= armed_ff | key_done;
    end
  end

  // read data one cycle after strobe; arm/kick and unmapped read as zero
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= `FLW_RST_READ;
    end else if (rd_period) begin
      reg_rdata_o <= 8'(period_ff); // see (R6)
    end else begin
      reg_rdata_o <= `FLW_RST_READ; // see (R2)
    end
  end

endmodule : flw_watchdog

// >>> core/flw_consts.svh
// register offsets, reset values and timing counts of the lockup watchdog
`ifndef FLW_CONSTS_SVH
`define FLW_CONSTS_SVH
`define FLW_ADDR_W             32
`define FLW_OFF_ARM_KICK_LOW   32'h01FF8040
`define FLW_OFF_ARM_KICK_HIGH  32'h01FF8041
`define FLW_OFF_PERIOD_LOW     32'h01FF8042
`define FLW_OFF_PERIOD_HIGH    32'h01FF8043
`define FLW_KEY_FIRST          8'h0F
`define FLW_KEY_SECOND         8'hF0
`define FLW_RST_PERIOD         8'h00
`define FLW_RST_READ           8'h00
`define FLW_CLK_PERIOD_NS      8
`define FLW_RST_HOLD_CLKS      8
`endif

// >>> core/flw_pkg.sv
// types shared by the lockup watchdog
package flw_pkg;
  typedef enum logic [1:0] {
    FLW_IDLE,
    FLW_SEEK_FIRST,
    FLW_SEEK_SECOND
  } flw_arm_t;
endpackage : flw_pkg

// >>> test/flw_watchdog_props.sv
// port assertions for the lockup watchdog
`timescale 1ns/1ps
`include "flw_consts.svh"
module flw_watchdog_props (
  // clock, reset and inputs
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [`FLW_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic millisecond_tick_i,
  // outputs watched
  input wire logic [7:0] reg_rdata_o,
  input wire logic wdog_int_rst_o,
  input wire logic board_rst_out_n_o,
  input wire logic wdog_armed_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // both resets move together, so one check covers the pair
  pair_a: assert property (board_rst_out_n_o != wdog_int_rst_o) else $error("split");
  idle_quiet_a: assert property (!wdog_armed_o |-> !wdog_int_rst_o) else $error("fire");
  armed_hold_a: assert property (wdog_armed_o |=> wdog_armed_o) else $error("stop");
  arm_key_a: assert property ($rose(wdog_armed_o) |->
    $past(reg_wr_i && reg_wdata_i == `FLW_KEY_SECOND)) else $error("arm");
  tick_fire_a: assert property ($rose(wdog_int_rst_o) |-> $past(millisecond_tick_i))
    else $error("tick");
  hold_eight_a: assert property ($rose(wdog_int_rst_o) |-> wdog_int_rst_o[*8] ##1
    !wdog_int_rst_o) else $error("hold");
  kick_zero_a: assert property (reg_rd_i && reg_addr_i == `FLW_OFF_ARM_KICK_LOW |=>
    reg_rdata_o == 8'h00) else $error("kick");
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("rd");
  // main scenarios
  cover property ($rose(wdog_armed_o));
  cover property ($rose(wdog_int_rst_o));
  cover property (reg_rd_i);
endmodule : flw_watchdog_props
bind flw_watchdog flw_watchdog_props u_props (.core_clk_i, .rst_b_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .millisecond_tick_i, .reg_rdata_o,
  .wdog_int_rst_o, .board_rst_out_n_o, .wdog_armed_o);

// >>> test/testbench.sv
// self-checking bench for the lockup watchdog
`timescale 1ns/1ps
`include "flw_consts.svh"
module testbench;
  localparam logic [31:0] ka = `FLW_OFF_ARM_KICK_LOW;
  localparam logic [31:0] pa = `FLW_OFF_PERIOD_LOW;
  localparam logic [7:0] k1 = `FLW_KEY_FIRST;
  localparam logic [7:0] k2 = `FLW_KEY_SECOND;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic tk = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rd, got, arm = 8'h00;
  logic irst, xrst_n, armed;
  integer prd = -1, ks = 0, cnt = 0, fire, n, cyc = 0;
  integer fail_count = 0, comparisons = 0, seed = 48708;
  always #4 clk = ~clk;
  flw_watchdog u_flw_watchdog (.core_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(adr),
    .reg_wdata_i(wd), .reg_wr_i(we), .reg_rd_i(re), .reg_rdata_o(rd), .millisecond_tick_i(tk),
    .wdog_int_rst_o(irst), .board_rst_out_n_o(xrst_n), .wdog_armed_o(armed));
  task chk(input logic [7:0] a, input logic [7:0] e);
    comparisons++;
    if (a !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, a, e);
    end
  endtask : chk
  // one strobe cycle, then a quiet cycle so strobes never change twice in a step
  task op(input logic w, r, k, input logic [31:0] a, input logic [7:0] d);
    {we, re, tk, adr, wd} <= {w, r, k, a, d};
    @(posedge clk);
    #1;
    got = rd;
    {we, re, tk} <= 3'h0;
    @(posedge clk);
    #1;
  endtask : op
  // write with the model of the period latch and key pairing beside it
  task w(input logic [31:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, 1'b0, a, d);
    if (a == pa && prd < 0) prd = d;
    if (a == ka && prd >= 0 && d == k1) ks = 1;
    if (a == ka && d == k2 && ks == 1) {ks, arm, cnt} = {32'd0, 8'h01, prd};
    chk({7'h0, armed}, arm);
  endtask : w
  task r(input logic [31:0] a, input logic [7:0] e);
    op(1'b0, 1'b1, 1'b0, a, 8'h00);
    chk(got, e);
  endtask : r
  task t();
    fire = (arm != 0 && cnt == 0);
    if (cnt > 0) cnt--;
    op(1'b0, 1'b0, 1'b1, 32'h0, 8'h00);
    chk({6'h0, irst, xrst_n}, fire ? 8'h02 : 8'h01);
  endtask : t
  task final_report();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    n = 2 + ($random(seed) & 3);
    w(ka, k1);
    w(ka, k2);
    t();
    w(pa, n[7:0]);
    w(pa, 8'($random(seed)));
    r(pa, n[7:0]);
    r(32'h01FF8041, 8'h00);
    r(32'h01FF8043, 8'h00);
    w(ka, k1);
    w(ka, 8'($random(seed)) & 8'h7F);
    w(ka, k2);
    r(ka, 8'h00);
    repeat (n) t();
    w(ka, k2);
    w(ka, k1);
    w(ka, k1);
    w(ka, k2);
    w(pa, 8'h00);
    w(ka, 8'h00);
    repeat (n + 1) t();
    repeat (8) @(posedge clk);
    #1;
    chk({6'h0, irst, xrst_n}, 8'h01);
    // second reset in mid-run: only a reset clears the armed state
    rst_b <= 1'b0;
    @(posedge clk);
    #1;
    rst_b <= 1'b1;
    {prd, ks, arm, cnt} = {-32'sd1, 32'd0, 8'h00, 32'd0};
    @(posedge clk);
    #1;
    chk({7'h0, armed}, 8'h00);
    chk({6'h0, irst, xrst_n}, 8'h01);
    w(pa, 8'h00);
    w(ka, k1);
    w(ka, k2);
    t();
    repeat (8) @(posedge clk);
    #1;
    chk({6'h0, irst, xrst_n}, 8'h01);
    final_report();
  end
endmodule : testbench
